// ==== rtl/hrp_pkg.sv ====
// shared constants for the host read port, both ends
package hrp_pkg;

    // ------------------------------------------------------------------
    // widths and timing
    // ------------------------------------------------------------------
    localparam int DATA_W          = 16;
    localparam int ADDR_W          = 8;
    localparam int BURST_MAX       = 16;
    localparam int CLK_NS          = 100;
    localparam int T_CYCLE_NS      = 165;
    localparam int T_LONG_NS       = 330;
    localparam int T_ASSERT_NS     = 32;
    localparam int T_DEASSERT_NS   = 13;
    localparam int T_ACYC_NS       = 165;
    // least times round up to whole clocks
    localparam int T_CYCLE_CLKS    = (T_CYCLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_LONG_CLKS     = (T_LONG_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_ASSERT_CLKS   = (T_ASSERT_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_DEASSERT_CLKS = (T_DEASSERT_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_ACYC_CLKS     = (T_ACYC_NS + CLK_NS - 1) / CLK_NS;
    // clocks that status indications stay frozen after a side-effect read
    localparam int STATUS_LAG_CLKS = 1;

    // ------------------------------------------------------------------
    // register map (word addresses on the port)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_RX_DATA     = 8'h00;
    localparam logic [7:0] OFS_RX_STATUS   = 8'h40;
    localparam logic [7:0] OFS_TX_STATUS   = 8'h48;
    localparam logic [7:0] OFS_ENDIAN_TEST = 8'h64;
    localparam logic [7:0] OFS_RECEIVE_DATAPATH_CONTROL  = 8'h78;
    localparam logic [7:0] OFS_RX_LEVEL    = 8'h7c;
    localparam logic [7:0] OFS_TX_LEVEL    = 8'h80;
    localparam logic [7:0] OFS_DROP        = 8'ha0;
    localparam logic [7:0] OFS_MAC_CMD     = 8'ha4;
    localparam logic [7:0] OFS_MAC_VAL     = 8'ha8;
    localparam logic [7:0] OFS_FLOW_CFG    = 8'hac;
    localparam logic [7:0] OFS_SMEM_CMD    = 8'hb0;
    localparam logic [7:0] OFS_SMEM_VAL    = 8'hb4;

    // fields and reset values
    localparam int          FFWD_BIT        = 0;
    localparam logic        FFWD_RST        = 1'b0;
    localparam logic [15:0] DROP_RST        = 16'h0000;
    // arbitrary pattern, names no part
    localparam logic [15:0] ENDIAN_PATTERN  = 16'h5aa5;

endpackage : hrp_pkg

// ==== rtl/hrp_if.sv ====
// pins of the asynchronous host read port between host and device
interface hrp_if;
    logic        chip_select_n;
    logic        read_strobe_n;
    logic        write_strobe_n;
    logic [7:0]  address;
    logic [15:0] dev_data_out;
    logic        dev_data_oe;
    logic [15:0] host_data_out;
    logic        host_data_oe;
    wire  [15:0] data_bus;

    // resolved level of the shared data lines
    assign data_bus = dev_data_oe  ? dev_data_out  :
                      host_data_oe ? host_data_out : ~dev_data_out;

    modport device (
        input  chip_select_n,
        input  read_strobe_n,
        input  write_strobe_n,
        input  address,
        input  data_bus,
        output dev_data_out,
        output dev_data_oe
    );

    modport host (
        output chip_select_n,
        output read_strobe_n,
        output write_strobe_n,
        output address,
        input  data_bus,
        output host_data_out,
        output host_data_oe
    );
endinterface : hrp_if

// ==== rtl/hrp_device.sv ====
// device end: register read decode, receive queue and status indications

// ----------------------------------------------------------------------
// receive data queue
// ----------------------------------------------------------------------
module hrp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic                         clock,
    input  wire logic                         reset,
    input  wire logic                         in_valid,
    input  wire logic [WIDTH-1:0]             in_data,
    output logic                              in_ready,
    output logic                              out_valid,
    output logic [WIDTH-1:0]                  out_data,
    input  wire logic                         out_ready,
    output logic [$clog2(DEPTH+1)-1:0]        level
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr_q;
    logic [PW-1:0]    rd_ptr_q;
    logic [CW-1:0]    count_q;
    logic             push;
    logic             pop;

    // honest full and empty straight from the count
    assign in_ready  = count_q != CW'(DEPTH);
    assign out_valid = count_q != '0;
    assign out_data  = mem[rd_ptr_q];
    assign level     = count_q;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // storage, no reset needed on the data
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    // pointers wrap at depth, which need not be a power of two
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            end
            count_q <= count_q + CW'(push) - CW'(pop);
        end
    end
endmodule : hrp_fifo

// ----------------------------------------------------------------------
// device end
// ----------------------------------------------------------------------
module hrp_device #(
    parameter int QUEUE_DEPTH = 4
) (
    input  wire logic        clock,
    input  wire logic        reset,
    hrp_if.device            bus,
    input  wire logic        rx_in_valid,
    input  wire logic [15:0] rx_in_data,
    output logic             rx_in_ready,
    input  wire logic        rx_status_valid,
    input  wire logic [15:0] rx_status_data,
    output logic             rx_status_pop,
    input  wire logic        tx_status_valid,
    input  wire logic [15:0] tx_status_data,
    output logic             tx_status_pop,
    input  wire logic        frame_dropped
);
    localparam int LW = $clog2(QUEUE_DEPTH + 1);

    logic             read_act;
    logic             act_q;
    logic [7:0]       addr_q;
    logic             word_start;
    logic             side_effect;
    logic [15:0]      read_value;
    logic [15:0]      data_q;
    logic             fifo_valid;
    logic [15:0]      fifo_data;
    logic             rx_pop;
    logic [LW-1:0]    fifo_level;
    logic [3:0]       lag_q;
    logic [15:0]      rx_level_q;
    logic [15:0]      tx_level_q;
    logic [15:0]      drop_q;
    logic             ffwd_q;
    logic             wr_act;
    logic             wr_q;
    logic [7:0]       wr_addr_q;
    logic [15:0]      wr_data_q;

    // a word begins when both strobes are low, or on an address change
    // inside a held assertion (burst)
    assign read_act   = ~bus.chip_select_n & ~bus.read_strobe_n;
    assign word_start = read_act & (~act_q | (bus.address != addr_q));
    assign side_effect = word_start & ((bus.address == hrp_pkg::OFS_RX_DATA)
                       | (bus.address == hrp_pkg::OFS_RX_STATUS)
                       | (bus.address == hrp_pkg::OFS_TX_STATUS)
                       | (bus.address == hrp_pkg::OFS_DROP));

    // previous strobe and address state for start detection
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            act_q  <= 1'b0;
            addr_q <= '0;
        end else begin
            act_q  <= read_act;
            addr_q <= bus.address;
        end
    end

    // queue pops, fast-forward drains one word a clock
    assign rx_pop        = (word_start & (bus.address == hrp_pkg::OFS_RX_DATA))
                         | ffwd_q;
    assign rx_status_pop = word_start & rx_status_valid
                         & (bus.address == hrp_pkg::OFS_RX_STATUS);
    assign tx_status_pop = word_start & tx_status_valid
                         & (bus.address == hrp_pkg::OFS_TX_STATUS);

    hrp_fifo #(
        .WIDTH (16),
        .DEPTH (QUEUE_DEPTH)
    ) u_rx_queue (
        .clock     (clock),
        .reset     (reset),
        .in_valid  (rx_in_valid),
        .in_data   (rx_in_data),
        .in_ready  (rx_in_ready),
        .out_valid (fifo_valid),
        .out_data  (fifo_data),
        .out_ready (rx_pop),
        .level     (fifo_level)
    );

    // read decode; values are those at the start of the word
    always_comb begin
        read_value = '0;
        unique case (bus.address)
            hrp_pkg::OFS_RX_DATA:     read_value = fifo_valid ? fifo_data : '0;
            hrp_pkg::OFS_RX_STATUS:   read_value = rx_status_valid ? rx_status_data : '0;
            hrp_pkg::OFS_TX_STATUS:   read_value = tx_status_valid ? tx_status_data : '0;
            hrp_pkg::OFS_ENDIAN_TEST: read_value = hrp_pkg::ENDIAN_PATTERN;
            hrp_pkg::OFS_RECEIVE_DATAPATH_CONTROL:  read_value[hrp_pkg::FFWD_BIT] = ffwd_q;
            hrp_pkg::OFS_RX_LEVEL:    read_value = rx_level_q;
            hrp_pkg::OFS_TX_LEVEL:    read_value = tx_level_q;
            hrp_pkg::OFS_DROP:        read_value = drop_q;
            default:                  read_value = '0;
        endcase
    end

    // latch the answer once per word so counters read as of that moment
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            data_q <= '0;
        end else if (word_start) begin
            data_q <= read_value;
        end
    end

    // drive the lines only inside an assertion
    assign bus.dev_data_oe  = read_act;
    assign bus.dev_data_out = data_q;

    // indications stay stale for a short lag after a side-effect read
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            lag_q <= '0;
        end else if (side_effect) begin
            lag_q <= 4'(hrp_pkg::STATUS_LAG_CLKS);
        end else if (lag_q != '0) begin
            lag_q <= lag_q - 1'b1;
        end
    end

    // level shadows follow live state only when the lag has run out
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rx_level_q <= '0;
            tx_level_q <= '0;
        end else if ((lag_q == '0) && !side_effect) begin
            rx_level_q <= {7'(0), rx_status_valid, 8'(fifo_level)};
            tx_level_q <= {15'(0), tx_status_valid};
        end
    end

    // dropped-frame count, cleared by reading; a drop in that clock wins
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            drop_q <= hrp_pkg::DROP_RST;
        end else if (word_start && (bus.address == hrp_pkg::OFS_DROP)) begin
            drop_q <= {15'(0), frame_dropped};
        end else if (frame_dropped && (drop_q != '1)) begin
            drop_q <= drop_q + 1'b1;
        end
    end

    // write capture; applied when the assertion ends, data is then settled
    assign wr_act = ~bus.chip_select_n & ~bus.write_strobe_n;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wr_q      <= 1'b0;
            wr_addr_q <= '0;
            wr_data_q <= '0;
        end else begin
            wr_q <= wr_act;
            if (wr_act) begin
                wr_addr_q <= bus.address;
                wr_data_q <= bus.data_bus;
            end
        end
    end

    // fast-forward bit: set by a write, self-clears once the queue is empty
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ffwd_q <= hrp_pkg::FFWD_RST;
        end else if (wr_q && !wr_act && (wr_addr_q == hrp_pkg::OFS_RECEIVE_DATAPATH_CONTROL)
                     && wr_data_q[hrp_pkg::FFWD_BIT]) begin
            ffwd_q <= 1'b1;
        end else if (ffwd_q && !fifo_valid) begin
            ffwd_q <= 1'b0;
        end
    end
endmodule : hrp_device

// ==== rtl/hrp_host.sv ====
// host end: issues single and burst reads and single-word writes with pacing waits
//
// Function
// - after write, wait 165 ns before restricted registers
// - queue read, wait 165 ns before level read
// - 330 ns between drop reads, control-to-status
// - control-to-status spacing only after fast-forward cleared
// - dummy endian reads may count toward waits
// - any method of waiting is acceptable
// - device updates indications late after side effects
// - device accepts single reads of registers, queues
// - device latches counters at read start
// - read cycle: both strobes low, ends either high
// - strobes high a minimum time between reads
// - each read cycle at least 165 ns
// - burst up to 16 words, 165 ns addresses
// - strobes high a minimum time between bursts
// - burst: both strobes low, ends either high
// - write-to-read wait depends on next register
module hrp_host (
    input  wire logic        clock,
    input  wire logic        reset,
    hrp_if.host              bus,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic        cmd_write,
    input  wire logic [7:0]  cmd_address,
    input  wire logic [15:0] cmd_wdata,
    input  wire logic [4:0]  cmd_words,
    output logic             rsp_valid,
    output logic [15:0]      rsp_data,
    output logic             rsp_last
);
    // ------------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        HRP_IDLE,
        HRP_GAP,
        HRP_ACTIVE
    } hrp_host_state_t;

    hrp_host_state_t state_q;
    logic            write_q;
    logic [7:0]      addr_q;
    logic [15:0]     wdata_q;
    logic [4:0]      words_q;
    logic [3:0]      phase_q;
    logic [7:0]      since_q;
    logic [7:0]      need_q;
    logic            last_write_q;
    logic [7:0]      last_addr_q;
    logic            ffwd_clear_q;
    logic [7:0]      need_d;
    logic            word_end;
    logic            hold_done;

    // ------------------------------------------------------------------
    // required idle time before the next cycle
    // ------------------------------------------------------------------
    function automatic logic [7:0] pace(input logic       nxt_write,
                                        input logic [7:0] nxt,
                                        input logic       prv_write,
                                        input logic [7:0] prv,
                                        input logic       ffwd_clear);
        logic [7:0] need;
        logic       is_status;
        need      = 8'(hrp_pkg::T_DEASSERT_CLKS);
        is_status = (nxt == hrp_pkg::OFS_RX_STATUS)
                  | (nxt == hrp_pkg::OFS_TX_STATUS);
        if (!nxt_write && prv_write) begin
            // write-to-read waits, chosen by the register read next
            if ((nxt == hrp_pkg::OFS_MAC_CMD) || (nxt == hrp_pkg::OFS_MAC_VAL)
                || (nxt == hrp_pkg::OFS_FLOW_CFG)
                || (nxt == hrp_pkg::OFS_SMEM_CMD)
                || (nxt == hrp_pkg::OFS_SMEM_VAL)) begin
                need = 8'(hrp_pkg::T_CYCLE_CLKS);
            end
        end else if (!nxt_write) begin
            if ((nxt == hrp_pkg::OFS_RX_LEVEL)
                && ((prv == hrp_pkg::OFS_RX_DATA)
                    || (prv == hrp_pkg::OFS_RX_STATUS))) begin
                need = 8'(hrp_pkg::T_CYCLE_CLKS);
            end
            if ((nxt == hrp_pkg::OFS_TX_LEVEL)
                && (prv == hrp_pkg::OFS_TX_STATUS)) begin
                need = 8'(hrp_pkg::T_CYCLE_CLKS);
            end
            if ((nxt == hrp_pkg::OFS_DROP) && (prv == hrp_pkg::OFS_DROP)) begin
                need = 8'(hrp_pkg::T_LONG_CLKS);
            end
            if (is_status && (prv == hrp_pkg::OFS_RECEIVE_DATAPATH_CONTROL) && ffwd_clear) begin
                need = 8'(hrp_pkg::T_LONG_CLKS);
            end
        end
        return need;
    endfunction : pace

    assign need_d = pace(cmd_write, cmd_address, last_write_q, last_addr_q,
                         ffwd_clear_q);

    // ------------------------------------------------------------------
    // pins
    // ------------------------------------------------------------------
    // both strobes fall and rise together; the device accepts any order
    assign bus.chip_select_n  = ~(state_q == HRP_ACTIVE);
    assign bus.read_strobe_n  = ~((state_q == HRP_ACTIVE) & ~write_q);
    assign bus.write_strobe_n = ~((state_q == HRP_ACTIVE) & write_q);
    assign bus.address        = addr_q;
    assign bus.host_data_out  = wdata_q;
    assign bus.host_data_oe   = (state_q == HRP_ACTIVE) & write_q;
    assign cmd_ready          = state_q == HRP_IDLE;

    // each word holds its address for a whole cycle time
    assign hold_done = phase_q >= 4'(hrp_pkg::T_CYCLE_CLKS - 1);
    assign word_end  = (state_q == HRP_ACTIVE) && hold_done
                     && (phase_q >= 4'(hrp_pkg::T_ASSERT_CLKS - 1));

    // ------------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------------
    // idle waiting meets every pacing figure, no dummy reads needed
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_q <= HRP_IDLE;
        end else begin
            unique case (state_q)
                HRP_IDLE: begin
                    if (cmd_valid) begin
                        state_q <= HRP_GAP;
                    end
                end
                HRP_GAP: begin
                    if (since_q >= need_q) begin
                        state_q <= HRP_ACTIVE;
                    end
                end
                HRP_ACTIVE: begin
                    if (word_end && (words_q <= 5'd1)) begin
                        state_q <= HRP_IDLE;
                    end
                end
            endcase
        end
    end

    // command capture and burst address stepping
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            write_q <= 1'b0;
            addr_q  <= '0;
            wdata_q <= '0;
            words_q <= '0;
            need_q  <= '0;
        end else if ((state_q == HRP_IDLE) && cmd_valid) begin
            write_q <= cmd_write;
            addr_q  <= cmd_address;
            wdata_q <= cmd_wdata;
            need_q  <= need_d;
            // writes and zero counts are single words, bursts cap at 16
            if (cmd_write || (cmd_words == 5'd0)) begin
                words_q <= 5'd1;
            end else if (cmd_words > 5'(hrp_pkg::BURST_MAX)) begin
                words_q <= 5'(hrp_pkg::BURST_MAX);
            end else begin
                words_q <= cmd_words;
            end
        end else if (word_end && (words_q > 5'd1)) begin
            addr_q  <= addr_q + 1'b1;
            words_q <= words_q - 1'b1;
        end
    end

    // clocks spent on the current word, restarts per burst word
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            phase_q <= '0;
        end else if ((state_q != HRP_ACTIVE) || word_end) begin
            phase_q <= '0;
        end else begin
            phase_q <= phase_q + 1'b1;
        end
    end

    // clocks with strobes high since the last cycle, saturating
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            since_q <= 8'hff;
        end else if (state_q == HRP_ACTIVE) begin
            since_q <= 8'h01;
        end else if (since_q != 8'hff) begin
            since_q <= since_q + 1'b1;
        end
    end

    // history that decides the next pacing wait
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            last_write_q <= 1'b0;
            last_addr_q  <= hrp_pkg::OFS_ENDIAN_TEST;
            ffwd_clear_q <= 1'b0;
        end else if (word_end) begin
            last_write_q <= write_q;
            last_addr_q  <= addr_q;
            // only a read showing the bit clear arms the long spacing
            if (!write_q && (addr_q == hrp_pkg::OFS_RECEIVE_DATAPATH_CONTROL)) begin
                ffwd_clear_q <= ~bus.data_bus[hrp_pkg::FFWD_BIT];
            end
        end
    end

    // read data sampled at the end of each word
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rsp_valid <= 1'b0;
            rsp_data  <= '0;
            rsp_last  <= 1'b0;
        end else begin
            rsp_valid <= word_end & ~write_q;
            rsp_last  <= word_end & ~write_q & (words_q <= 5'd1);
            if (word_end && !write_q) begin
                rsp_data <= bus.data_bus;
            end
        end
    end
endmodule : hrp_host

// ==== bench/hrp_chk.sv ====
// checker on the read port pins between host and device ends
module hrp_chk (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        chip_select_n,
    input wire logic        read_strobe_n,
    input wire logic        write_strobe_n,
    input wire logic [7:0]  address,
    input wire logic        dev_data_oe,
    input wire logic [15:0] dev_data_out
);
    // ------------------------------------------------------------------
    // pin relations
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    logic       rd;
    logic [5:0] run_q;
    assign rd = !chip_select_n && !read_strobe_n;
    // clocks low in one burst; 16 words of 2 clocks at most
    always_ff @(posedge clock or posedge reset) begin
        if (reset)
            run_q <= 6'h00;
        else
            run_q <= rd ? run_q + 6'h01 : 6'h00;
    end
    drive_only_a: assert property (dev_data_oe == rd)
        else $error("data lines driven outside a read");
    assert_len_a: assert property ($rose(rd) |-> rd [*2])
        else $error("read assertion shorter than two clocks");
    burst_cap_a: assert property (run_q <= 6'h20)
        else $error("burst longer than sixteen words");
    addr_cycle_a: assert property (rd && $changed(address)
        |=> !rd || $stable(address)) else $error("address cycle too short");
    wr_to_csr_a: assert property ($rose(write_strobe_n)
        |=> !(rd && address inside {[8'ha4:8'hb4]}))
        else $error("restricted read too soon after write");
    lvl_wait_a: assert property ($rose(read_strobe_n)
        && $past(address) inside {8'h00, 8'h40} |=> !(rd && address == 8'h7c))
        else $error("level read too soon after queue read");
    drop_gap_a: assert property ($rose(read_strobe_n)
        && $past(address) == 8'ha0 |=> !(rd && address == 8'ha0) [*3])
        else $error("drop counter reads too close");
    endian_a: assert property (rd && $past(rd) && $stable(address)
        && address == 8'h64 |-> dev_data_out == hrp_pkg::ENDIAN_PATTERN)
        else $error("wrong endian test word");
    burst_c: cover property (rd && $past(rd) && $changed(address));
    write_c: cover property ($rose(write_strobe_n));
    drop_c: cover property ($rose(read_strobe_n) && $past(address) == 8'ha0);
endmodule : hrp_chk

// ==== bench/tb_top.sv ====
// self-checking bench joining host and device ends of the read port
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic wr; logic [7:0] addr; logic [4:0] words; logic [15:0] exp;
    } hrp_row_t;
    logic        clock, reset, cmd_valid, cmd_write, cmd_ready, rsp_valid;
    logic        rsp_last, rx_in_valid, rx_in_ready, frame_dropped, tx_pop;
    logic [7:0]  cmd_address;
    logic [4:0]  cmd_words;
    logic [15:0] rsp_data, rx_in_data, first;
    int          err_total, checks, n, k, pops;
    hrp_row_t    rows [8];
    hrp_if hrp_if_inst ();
    hrp_device hrp_device_inst (.clock, .reset, .bus(hrp_if_inst),
        .rx_in_valid, .rx_in_data, .rx_in_ready, .rx_status_valid(1'b0),
        .rx_status_data(16'h0000), .rx_status_pop(), .tx_status_valid(1'b1),
        .tx_status_data(16'h1234), .tx_status_pop(tx_pop), .frame_dropped);
    hrp_host hrp_host_inst (.clock, .reset, .bus(hrp_if_inst), .cmd_valid,
        .cmd_ready, .cmd_write, .cmd_address, .cmd_wdata(16'h0000), .cmd_words,
        .rsp_valid, .rsp_data, .rsp_last);
    hrp_chk hrp_chk_inst (.clock, .reset,
        .chip_select_n(hrp_if_inst.chip_select_n),
        .read_strobe_n(hrp_if_inst.read_strobe_n),
        .write_strobe_n(hrp_if_inst.write_strobe_n),
        .address(hrp_if_inst.address), .dev_data_oe(hrp_if_inst.dev_data_oe),
        .dev_data_out(hrp_if_inst.dev_data_out));
    // 100 ns clock
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // pops of the status queue
    always_ff @(posedge clock) pops <= pops + int'(tx_pop);
    // one command, words counted until the last one comes back
    task automatic op(input hrp_row_t r);
        @(posedge clock);
        cmd_valid <= 1'b1;
        {cmd_write, cmd_address, cmd_words} <= {r.wr, r.addr, r.words};
        @(posedge clock);
        while (cmd_ready !== 1'b1) @(posedge clock);
        cmd_valid <= 1'b0;
        n = 0;
        while (!r.wr && rsp_last !== 1'b1) begin
            @(posedge clock);
            if (rsp_valid === 1'b1 && n++ == 0) first = rsp_data;
        end
    endtask : op
    task automatic cmp(input string s, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask : cmp
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    // watchdog well past the 135 or so clocks the tests need
    initial begin
        repeat (6000) @(posedge clock);
        err_total++;
        end_sim();
    end
    // main sequence
    initial begin
        {cmd_valid, cmd_write, rx_in_valid, frame_dropped, reset} = 5'h01;
        {cmd_address, cmd_words, rx_in_data, err_total, checks} = '0;
        rows = '{{1'b0, 8'h64, 5'h01, 16'h5aa5}, {1'b0, 8'h10, 5'h01, 16'h0000},
                 {1'b1, 8'h78, 5'h01, 16'h0000}, {1'b0, 8'ha4, 5'h01, 16'h0000},
                 {1'b0, 8'h48, 5'h01, 16'h1234}, {1'b0, 8'h80, 5'h01, 16'h0001},
                 {1'b0, 8'h00, 5'h01, 16'h0000}, {1'b0, 8'h7c, 5'h01, 16'h0000}};
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        cmp("oe", 16'h0000, {15'h0, hrp_if_inst.dev_data_oe});
        for (int i = 0; i < 8; i++) begin
            op(rows[i]);
            if (!rows[i].wr) cmp("row", rows[i].exp, first);
            $display("test row %0d done", i);
        end
        // fill the queue until it refuses, then check level and drain
        rx_in_valid <= 1'b1;
        rx_in_data <= 16'h0a00;
        for (k = 0; k < 8; k++) begin
            @(posedge clock);
            if (rx_in_ready !== 1'b1) break;
            rx_in_data <= 16'h0a01 + 16'(k);
        end
        rx_in_valid <= 1'b0;
        cmp("pushed", 16'h0004, 16'(k));
        op({1'b0, 8'h7c, 5'h01, 16'h0});
        cmp("level", 16'h0004, first);
        for (int i = 0; i < 5; i++) begin
            op({1'b0, 8'h00, 5'h01, 16'h0});
            cmp("rxdata", i < 4 ? 16'h0a00 + 16'(i) : 16'h0, first);
        end
        $display("test queue done");
        // burst of three words across the endian test word
        op({1'b0, 8'h63, 5'h03, 16'h0});
        cmp("burst words", 16'h0003, 16'(n));
        cmp("burst first", 16'h0000, first);
        $display("test burst done");
        // drop counter latched at read start, cleared by the read
        repeat (3) begin
            @(posedge clock) frame_dropped <= 1'b1;
            @(posedge clock) frame_dropped <= 1'b0;
        end
        op({1'b0, 8'ha0, 5'h01, 16'h0});
        cmp("drops", 16'h0003, first);
        op({1'b0, 8'ha0, 5'h01, 16'h0});
        cmp("drops cleared", 16'h0000, first);
        // reset mid-run clears a drop
        @(posedge clock) frame_dropped <= 1'b1;
        @(posedge clock) {frame_dropped, reset} <= 2'b01;
        @(posedge clock) reset <= 1'b0;
        op({1'b0, 8'ha0, 5'h01, 16'h0});
        cmp("drop reset", 16'h0000, first);
        cmp("tx pops", 16'h0001, 16'(pops));
        $display("test drop done");
        end_sim();
    end
endmodule : tb_top
